//--- rtl/caa_core_alu.sv
// Accumulator datapath with operand addressing for the microcontroller core
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Indexed address is accumulator plus pointer or program counter
// - Indexed mode only reads program memory, never writes
// - Immediate operand comes from program byte following the opcode
// - Accumulator and pointer operations need no address byte
// - Add, add with carry, subtract with borrow on any operand mode
// - Increment and decrement act on accumulator or memory byte in place
// - Pointer increment carries from low into high byte at once
// - Multiply puts high product byte in B, low byte in accumulator
// - Divide puts quotient in accumulator, remainder in B
// - Decimal adjust corrects accumulator after a BCD add
// - AND, OR, XOR work independently per bit
// - Accumulator logic takes all modes; memory forms use direct or immediate only
// - Memory logic forms leave the accumulator untouched
// - Plain rotates wrap the end bit round by one place
// - Carry rotates form a nine-bit ring with the accumulator
// - Swap exchanges accumulator nibbles
// - Register mode bank chosen by two status word bits
module caa_core_alu
  import caa_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // Decoder command
  input wire logic START,
  input wire caa_pkg::caa_op_t OP,
  input wire caa_pkg::caa_mode_t MODE,
  input wire logic MEM_DEST,
  input wire logic [7:0] ADDR_FIELD,
  input wire logic [2:0] REG_SEL,
  input wire logic [15:0] PC_IN,
  output logic BUSY,
  output logic DONE,
  // Program memory read port
  output logic [15:0] PMEM_ADDR,
  output logic PMEM_RD,
  input wire logic [7:0] PMEM_DATA,
  // Internal data memory port
  output logic [7:0] DMEM_ADDR,
  output logic DMEM_RD,
  output logic DMEM_WR,
  output logic [7:0] DMEM_WDATA,
  input wire logic [7:0] DMEM_RDATA,
  // Architectural registers
  output logic [7:0] ACC,
  output logic [7:0] B_REG,
  output logic [15:0] DATA_POINTER_REG,
  output logic [7:0] PROGRAM_STATUS_WORD,
  // Software-side loads of status word and pointer
  input wire logic PSW_LOAD,
  input wire logic [7:0] PSW_DATA,
  input wire logic DATA_POINTER_REG_LOAD,
  input wire logic [15:0] DATA_POINTER_REG_DATA
);
  import caa_pkg::*;

  caa_state_t state_ff, nxt_state;
  caa_op_t op_ff;
  caa_mode_t mode_ff;
  logic mdst_ff;
  logic [7:0] afield_ff;
  logic [15:0] pc_ff;
  logic [7:0] opnd_ff;
  logic [7:0] maddr_ff;
  logic [7:0] acc_ff, b_ff, psw_ff;
  logic [15:0] data_pointer_reg_ff;
  logic done_ff;
  logic [3:0] div_cnt_ff;
  logic [7:0] rem_ff, quo_ff;
  logic [7:0] bank_base;
  logic [7:0] add_sum;
  logic add_c, add_ac, add_ov;
  logic [7:0] add_b;
  logic add_cin, add_sub;
  logic [15:0] product;
  logic [8:0] da_tmp;
  logic [7:0] res_acc, res_mem, res_b;
  logic wr_acc, wr_mem, wr_b, upd_flags, div_last;
  logic [8:0] rem_shift;
  logic needs_ptr, needs_opnd;

  ////////////////////////////////////////////////////////////////////////
  // Addressing
  assign bank_base = {3'h0, psw_ff[PSW_RS1], psw_ff[PSW_RS0], 3'h0};
  assign needs_ptr = (mode_ff == AM_INDIRECT);
  // Memory-destination immediate forms read the target byte first
  assign needs_opnd = (mode_ff == AM_DIRECT) || (mode_ff == AM_INDIRECT) ||
                      (mode_ff == AM_REG) ||
                      (mode_ff == AM_IMM && mdst_ff);

  // Sequencer next state
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (START) begin
          nxt_state = (MODE == AM_INDIRECT) ? ST_PTR :
                      ((MODE == AM_ACC) ? ST_EXEC : ST_OPND);
        end
      end
      ST_PTR: nxt_state = ST_OPND;
      ST_OPND: nxt_state = ST_EXEC;
      ST_EXEC: begin
        if (op_ff != OP_DIV || div_last) begin
          nxt_state = ST_IDLE;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Command capture
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      op_ff <= OP_NOP;
      mode_ff <= AM_ACC;
      mdst_ff <= 1'b0;
      afield_ff <= 8'h00;
      pc_ff <= 16'h0000;
    end else if (state_ff == ST_IDLE && START) begin
      op_ff <= OP;
      mode_ff <= MODE;
      mdst_ff <= MEM_DEST;
      afield_ff <= ADDR_FIELD;
      pc_ff <= PC_IN;
    end
  end

  // Memory address and operand capture
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      maddr_ff <= 8'h00;
      opnd_ff <= 8'h00;
    end else if (state_ff == ST_IDLE && START) begin
      maddr_ff <= (MODE == AM_REG) ? bank_base + {5'h00, REG_SEL}
                                   : ADDR_FIELD;
    end else if (state_ff == ST_PTR) begin
      maddr_ff <= DMEM_RDATA; // Pointer register content
    end else if (state_ff == ST_OPND) begin
      opnd_ff <= ((mode_ff == AM_IMM && !mdst_ff) || mode_ff == AM_DATA_POINTER_REG ||
                  mode_ff == AM_PC) ? PMEM_DATA : DMEM_RDATA;
    end
  end

  // Indirect pointer is R0 or R1 of the active bank
  always_comb begin
    DMEM_ADDR = maddr_ff;
    if (state_ff == ST_PTR) begin
      DMEM_ADDR = bank_base + {7'h00, afield_ff[0]};
    end
    DMEM_RD = (state_ff == ST_PTR) || (state_ff == ST_OPND && needs_opnd);
  end

  // Program memory: immediate byte or indexed table, read only
  always_comb begin
    PMEM_ADDR = pc_ff;
    if (mode_ff == AM_DATA_POINTER_REG) begin
      PMEM_ADDR = data_pointer_reg_ff + {8'h00, acc_ff};
    end else if (mode_ff == AM_PC) begin
      PMEM_ADDR = pc_ff + {8'h00, acc_ff};
    end
    PMEM_RD = ((state_ff == ST_OPND) && !needs_opnd) ||
              ((state_ff == ST_EXEC) && mode_ff == AM_IMM && mdst_ff);
  end

  ////////////////////////////////////////////////////////////////////////
  // Arithmetic
  always_comb begin
    add_b = opnd_ff;
    add_cin = 1'b0;
    add_sub = 1'b0;
    unique case (op_ff)
      OP_ADD_WITH_CARRY: add_cin = psw_ff[PSW_CY];
      OP_SUBTRACT_WITH_BORROW: begin
        add_sub = 1'b1;
        add_cin = psw_ff[PSW_CY];
      end
      OP_INC: begin
        add_b = 8'h01;
      end
      OP_DEC: begin
        add_b = 8'h01;
        add_sub = 1'b1;
      end
      default: add_b = opnd_ff;
    endcase
  end

  caa_adder u_adder (
    .a((op_ff == OP_INC || op_ff == OP_DEC) && mode_ff != AM_ACC ?
       opnd_ff : acc_ff),
    .b(add_b),
    .cin(add_cin),
    .sub(add_sub),
    .sum(add_sum),
    .cout(add_c),
    .acout(add_ac),
    .ovout(add_ov)
  );

  assign product = {8'h00, acc_ff} * {8'h00, b_ff};
  assign rem_shift = {rem_ff, quo_ff[7]};
  assign div_last = (div_cnt_ff == 4'(DIV_STEPS));

  // Decimal adjust of the accumulator
  always_comb begin
    da_tmp = {1'b0, acc_ff};
    if (acc_ff[3:0] > 4'h9 || psw_ff[PSW_AC]) begin
      da_tmp = da_tmp + {1'b0, BCD_FIX};
    end
    if (da_tmp[7:4] > 4'h9 || da_tmp[8] || psw_ff[PSW_CY]) begin
      da_tmp = da_tmp + {1'b0, BCD_HI_FIX};
    end
  end

  // Result select and write targets
  always_comb begin
    res_acc = acc_ff;
    res_mem = opnd_ff;
    res_b = b_ff;
    wr_acc = 1'b0;
    wr_mem = 1'b0;
    wr_b = 1'b0;
    upd_flags = 1'b0;
    unique case (op_ff)
      OP_ADD, OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW: begin
        res_acc = add_sum;
        wr_acc = 1'b1;
        upd_flags = 1'b1;
      end
      OP_INC, OP_DEC: begin
        res_acc = add_sum;
        res_mem = add_sum;
        wr_acc = (mode_ff == AM_ACC);
        wr_mem = (mode_ff != AM_ACC);
      end
      OP_MUL: begin
        res_acc = product[7:0];
        res_b = product[15:8];
        wr_acc = 1'b1;
        wr_b = 1'b1;
      end
      OP_DIV: begin
        res_acc = quo_ff;
        res_b = rem_ff;
        wr_acc = div_last;
        wr_b = div_last;
      end
      OP_DA: begin
        res_acc = da_tmp[7:0];
        wr_acc = 1'b1;
      end
      OP_AND, OP_OR, OP_XOR: begin
        if (op_ff == OP_AND) begin
          res_mem = opnd_ff & (mode_ff == AM_IMM ? PMEM_DATA : acc_ff);
        end else if (op_ff == OP_OR) begin
          res_mem = opnd_ff | (mode_ff == AM_IMM ? PMEM_DATA : acc_ff);
        end else begin
          res_mem = opnd_ff ^ (mode_ff == AM_IMM ? PMEM_DATA : acc_ff);
        end
        res_acc = (op_ff == OP_AND) ? acc_ff & opnd_ff :
                  (op_ff == OP_OR) ? acc_ff | opnd_ff :
                  acc_ff ^ opnd_ff;
        wr_mem = mdst_ff && (mode_ff == AM_DIRECT || mode_ff == AM_IMM);
        wr_acc = !mdst_ff;
      end
      OP_CLR: begin
        res_acc = 8'h00;
        wr_acc = 1'b1;
      end
      OP_CPL: begin
        res_acc = ~acc_ff;
        wr_acc = 1'b1;
      end
      OP_RL: begin
        res_acc = {acc_ff[6:0], acc_ff[7]};
        wr_acc = 1'b1;
      end
      OP_RR: begin
        res_acc = {acc_ff[0], acc_ff[7:1]};
        wr_acc = 1'b1;
      end
      OP_RLC: begin
        res_acc = {acc_ff[6:0], psw_ff[PSW_CY]};
        wr_acc = 1'b1;
      end
      OP_RRC: begin
        res_acc = {psw_ff[PSW_CY], acc_ff[7:1]};
        wr_acc = 1'b1;
      end
      OP_SWAP: begin
        res_acc = {acc_ff[3:0], acc_ff[7:4]};
        wr_acc = 1'b1;
      end
      OP_IDX_RD: begin
        res_acc = opnd_ff;
        wr_acc = 1'b1;
      end
      default: res_acc = acc_ff;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Restoring divider, one quotient bit per cycle
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      div_cnt_ff <= 4'h0;
      rem_ff <= 8'h00;
      quo_ff <= 8'h00;
    end else if (state_ff == ST_EXEC && op_ff == OP_DIV && !div_last) begin
      div_cnt_ff <= div_cnt_ff + 4'h1;
      if (rem_shift >= {1'b0, b_ff}) begin
        rem_ff <= 8'(rem_shift - {1'b0, b_ff});
        quo_ff <= {quo_ff[6:0], 1'b1};
      end else begin
        rem_ff <= rem_shift[7:0];
        quo_ff <= {quo_ff[6:0], 1'b0};
      end
    end else if (state_ff != ST_EXEC) begin
      div_cnt_ff <= 4'h0;
      rem_ff <= 8'h00;
      quo_ff <= acc_ff;
    end
  end

  // Accumulator and B
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      acc_ff <= ACC_RST;
      b_ff <= B_RST;
    end else if (state_ff == ST_EXEC) begin
      if (wr_acc) begin
        acc_ff <= res_acc;
      end
      if (wr_b) begin
        b_ff <= res_b;
      end
    end
  end

  // Data pointer, full sixteen-bit increment
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      data_pointer_reg_ff <= DATA_POINTER_REG_RST;
    end else if (state_ff == ST_EXEC && op_ff == OP_INC_DP) begin
      data_pointer_reg_ff <= data_pointer_reg_ff + 16'h0001;
    end else if (DATA_POINTER_REG_LOAD) begin
      data_pointer_reg_ff <= DATA_POINTER_REG_DATA;
    end
  end

  // Status word flags
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      psw_ff <= PSW_RST;
    end else if (state_ff == ST_EXEC && upd_flags) begin
      psw_ff[PSW_CY] <= add_c;
      psw_ff[PSW_AC] <= add_ac;
      psw_ff[PSW_OV] <= add_ov;
    end else if (state_ff == ST_EXEC && (op_ff == OP_MUL ||
                 (op_ff == OP_DIV && div_last))) begin
      psw_ff[PSW_CY] <= 1'b0;
      psw_ff[PSW_OV] <= (op_ff == OP_MUL) ? (product[15:8] != 8'h00)
                                          : (b_ff == 8'h00);
    end else if (state_ff == ST_EXEC && (op_ff == OP_RLC || op_ff == OP_RRC
                 || op_ff == OP_DA)) begin
      psw_ff[PSW_CY] <= (op_ff == OP_RLC) ? acc_ff[7] :
                        (op_ff == OP_RRC) ? acc_ff[0] :
                        (da_tmp[8] | psw_ff[PSW_CY]);
    end else if (PSW_LOAD) begin
      psw_ff <= PSW_DATA;
    end
  end

  // Completion pulse
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= (state_ff == ST_EXEC) && (nxt_state == ST_IDLE);
    end
  end

  // Outputs
  assign DMEM_WR = (state_ff == ST_EXEC) && wr_mem;
  assign DMEM_WDATA = res_mem;
  assign BUSY = (state_ff != ST_IDLE);
  assign DONE = done_ff;
  assign ACC = acc_ff;
  assign B_REG = b_ff;
  assign DATA_POINTER_REG = data_pointer_reg_ff;
  assign PROGRAM_STATUS_WORD = {psw_ff[7:1], ^acc_ff};
endmodule
`default_nettype wire

//--- common/caa_pkg.sv
// Package: operation codes, addressing modes and reset values of the datapath
`default_nettype none
package caa_pkg;
  // Operation selected by the decoder
  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_ADD = 5'h01, OP_ADD_WITH_CARRY = 5'h02, OP_SUBTRACT_WITH_BORROW = 5'h03,
    OP_INC = 5'h04, OP_DEC = 5'h05, OP_INC_DP = 5'h06, OP_MUL = 5'h07,
    OP_DIV = 5'h08, OP_DA = 5'h09, OP_AND = 5'h0a, OP_OR = 5'h0b,
    OP_XOR = 5'h0c, OP_CLR = 5'h0d, OP_CPL = 5'h0e, OP_RL = 5'h0f,
    OP_RLC = 5'h10, OP_RR = 5'h11, OP_RRC = 5'h12, OP_SWAP = 5'h13,
    OP_IDX_RD = 5'h14
  } caa_op_t;
  // Operand addressing mode
  typedef enum logic [2:0] {
    AM_ACC = 3'h0, AM_DIRECT = 3'h1, AM_INDIRECT = 3'h2, AM_REG = 3'h3,
    AM_IMM = 3'h4, AM_DATA_POINTER_REG = 3'h5, AM_PC = 3'h6
  } caa_mode_t;
  // Sequencer states, gray along idle-fetch-exec
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_PTR = 2'b01, ST_OPND = 2'b11, ST_EXEC = 2'b10
  } caa_state_t;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] B_RST = 8'h00;
  localparam logic [15:0] DATA_POINTER_REG_RST = 16'h0000;
  localparam logic [7:0] PSW_RST = 8'h00;
  // Status word bit positions
  localparam int PSW_CY = 7;
  localparam int PSW_AC = 6;
  localparam int PSW_RS1 = 4;
  localparam int PSW_RS0 = 3;
  localparam int PSW_OV = 2;
  localparam int PSW_P = 0;
  localparam int DIV_STEPS = 8;
  localparam logic [7:0] BCD_FIX = 8'h06;
  localparam logic [7:0] BCD_HI_FIX = 8'h60;
endpackage
`default_nettype wire

//--- rtl/caa_adder.sv
// Eight-bit adder with carry, auxiliary carry and overflow outputs
`timescale 1ns/1ps
`default_nettype none
module caa_adder (
  // Operands
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic cin,
  input wire logic sub,
  // Results
  output logic [7:0] sum,
  output logic cout,
  output logic acout,
  output logic ovout
);
  logic [7:0] bx;
  logic [4:0] lo;
  logic [3:0] mid;
  logic [1:0] top;
  // Subtract as add of inverted operand, borrow inverted
  always_comb begin
    bx = sub ? ~b : b;
    lo = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, cin ^ sub};
    mid = {1'b0, a[6:4]} + {1'b0, bx[6:4]} + {3'h0, lo[4]};
    top = {1'b0, a[7]} + {1'b0, bx[7]} + {1'b0, mid[3]};
    sum = {top[0], mid[2:0], lo[3:0]};
    cout = top[1] ^ sub;
    acout = lo[4] ^ sub;
    ovout = top[1] ^ mid[3];
  end
endmodule
`default_nettype wire

//--- dv/caa_core_alu_asserts.sv
// Checker for timing and results of the core datapath
`timescale 1ns/1ps
`default_nettype none
module caa_core_alu_chk
  import caa_pkg::*;
(
  // Watched top-level ports
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic START,
  input wire caa_pkg::caa_op_t OP,
  input wire caa_pkg::caa_mode_t MODE,
  input wire logic MEM_DEST,
  input wire logic [15:0] PC_IN,
  input wire logic BUSY,
  input wire logic DONE,
  input wire logic [15:0] PMEM_ADDR,
  input wire logic PMEM_RD,
  input wire logic DMEM_RD,
  input wire logic DMEM_WR,
  input wire logic [7:0] ACC,
  input wire logic [15:0] DATA_POINTER_REG,
  input wire logic [7:0] PROGRAM_STATUS_WORD
);
  import caa_pkg::*;
  logic take;
  caa_op_t op_ff;
  logic [7:0] acc_ff;
  logic [15:0] dp_ff;
  logic cy_ff;
  assign take = START && !BUSY;
  // Operands captured when a command is taken
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      op_ff <= OP_NOP;
      acc_ff <= 8'h00;
      dp_ff <= 16'h0000;
      cy_ff <= 1'b0;
    end else if (take) begin
      op_ff <= OP;
      acc_ff <= ACC;
      dp_ff <= DATA_POINTER_REG;
      cy_ff <= PROGRAM_STATUS_WORD[PSW_CY];
    end
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////////////////////////////////////
  a_done_one_cycle: assert property (DONE |=> !DONE)
    else $error("done longer than one cycle");
  a_take_busy: assert property (take |=> BUSY)
    else $error("busy not raised after take");
  a_acc_latency: assert property (take && MODE == AM_ACC && OP != OP_DIV
    |-> ##2 DONE) else $error("accumulator op latency wrong");
  a_imm_latency: assert property (take && MODE == AM_IMM && OP != OP_DIV
    |-> !DONE [*3] ##1 DONE) else $error("immediate latency wrong");
  a_ind_latency: assert property (take && MODE == AM_INDIRECT &&
    OP != OP_DIV |-> ##4 DONE) else $error("indirect latency wrong");
  a_imm_fetch: assert property (take && MODE == AM_IMM |-> ##[1:2]
    (PMEM_RD && PMEM_ADDR == PC_IN)) else $error("immediate not fetched");
  a_acc_no_fetch: assert property (take && MODE == AM_ACC |=>
    (!PMEM_RD && !DMEM_RD) [*2]) else $error("operand fetched");
  a_idx_read_only: assert property (BUSY && (MODE == AM_DATA_POINTER_REG ||
    MODE == AM_PC) |-> !DMEM_WR) else $error("indexed write");
  a_idx_address: assert property (take && OP == OP_IDX_RD &&
    MODE == AM_DATA_POINTER_REG |-> ##[1:2] (PMEM_RD && PMEM_ADDR ==
    DATA_POINTER_REG + {8'h00, ACC})) else $error("indexed address");
  a_memdest_keep: assert property (take && MEM_DEST |=> $stable(ACC) [*3])
    else $error("accumulator changed by memory op");
  a_swap_result: assert property (DONE && op_ff == OP_SWAP |->
    ACC == {acc_ff[3:0], acc_ff[7:4]}) else $error("swap wrong");
  a_rotate_left: assert property (DONE && op_ff == OP_RL |->
    ACC == {acc_ff[6:0], acc_ff[7]}) else $error("rotate wrong");
  a_rotate_carry: assert property (DONE && op_ff == OP_RLC |->
    {PROGRAM_STATUS_WORD[PSW_CY], ACC} == {acc_ff, cy_ff})
    else $error("carry rotate wrong");
  a_data_pointer_reg_step: assert property (DONE && op_ff == OP_INC_DP |->
    DATA_POINTER_REG == dp_ff + 16'h0001) else $error("pointer step");
  c_indirect: cover property (take && MODE == AM_INDIRECT);
  c_memdest: cover property (take && MEM_DEST);
  c_divide: cover property (DONE && op_ff == OP_DIV);
endmodule
bind caa_core_alu caa_core_alu_chk chk_u (.CLOCK(CLOCK), .RST_N(RST_N),
  .START(START), .OP(OP), .MODE(MODE), .MEM_DEST(MEM_DEST), .PC_IN(PC_IN),
  .BUSY(BUSY), .DONE(DONE), .PMEM_ADDR(PMEM_ADDR), .PMEM_RD(PMEM_RD),
  .DMEM_RD(DMEM_RD), .DMEM_WR(DMEM_WR), .ACC(ACC),
  .DATA_POINTER_REG(DATA_POINTER_REG),
  .PROGRAM_STATUS_WORD(PROGRAM_STATUS_WORD));
`default_nettype wire

//--- dv/caa_tb.sv
// Self-checking bench for the core datapath
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import caa_pkg::*;
  logic CLOCK = 1'b0;
  logic RST_N = 1'b0;
  logic START = 1'b0;
  logic MEM_DEST = 1'b0;
  logic PSW_LOAD = 1'b0;
  logic DATA_POINTER_REG_LOAD = 1'b0;
  caa_op_t OP = OP_NOP;
  caa_mode_t MODE = AM_ACC;
  logic [7:0] ADDR_FIELD = 8'h00;
  logic [7:0] PSW_DATA = 8'h00;
  logic [2:0] REG_SEL = 3'h0;
  logic [15:0] PC_IN = 16'h0000;
  logic [15:0] DATA_POINTER_REG_DATA = 16'h0000;
  logic BUSY, DONE, PMEM_RD, DMEM_RD, DMEM_WR;
  logic [15:0] PMEM_ADDR, DATA_POINTER_REG;
  logic [7:0] PMEM_DATA, DMEM_ADDR, DMEM_WDATA, DMEM_RDATA, ACC, B_REG;
  logic [7:0] PROGRAM_STATUS_WORD;
  logic [7:0] dmem [256];
  int n_mismatch = 0;
  int tests_run = 0;
  // Clock of 40 ns period
  always #20 CLOCK = ~CLOCK;
  // Program byte is address low xor high; data memory written at edge
  assign PMEM_DATA = PMEM_ADDR[7:0] ^ PMEM_ADDR[15:8];
  assign DMEM_RDATA = dmem[DMEM_ADDR];
  always @(posedge CLOCK) if (DMEM_WR) dmem[DMEM_ADDR] <= DMEM_WDATA;
  caa_core_alu dut_u (.CLOCK(CLOCK), .RST_N(RST_N), .START(START),
    .OP(OP), .MODE(MODE), .MEM_DEST(MEM_DEST), .ADDR_FIELD(ADDR_FIELD),
    .REG_SEL(REG_SEL), .PC_IN(PC_IN), .BUSY(BUSY), .DONE(DONE),
    .PMEM_ADDR(PMEM_ADDR), .PMEM_RD(PMEM_RD), .PMEM_DATA(PMEM_DATA),
    .DMEM_ADDR(DMEM_ADDR), .DMEM_RD(DMEM_RD), .DMEM_WR(DMEM_WR),
    .DMEM_WDATA(DMEM_WDATA), .DMEM_RDATA(DMEM_RDATA), .ACC(ACC),
    .B_REG(B_REG), .DATA_POINTER_REG(DATA_POINTER_REG),
    .PROGRAM_STATUS_WORD(PROGRAM_STATUS_WORD), .PSW_LOAD(PSW_LOAD),
    .PSW_DATA(PSW_DATA), .DATA_POINTER_REG_LOAD(DATA_POINTER_REG_LOAD), .DATA_POINTER_REG_DATA(DATA_POINTER_REG_DATA));
  ////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One command, held until done; register number rides on ad[2:0]
  task automatic run(input caa_op_t op, input caa_mode_t md,
    input logic [7:0] ad, input logic [15:0] pc, input logic m = 1'b0);
    int i;
    @(negedge CLOCK);
    OP = op;
    MODE = md;
    ADDR_FIELD = ad;
    REG_SEL = ad[2:0];
    PC_IN = pc;
    MEM_DEST = m;
    START = 1'b1;
    @(negedge CLOCK);
    START = 1'b0;
    for (i = 0; i < 30 && DONE !== 1'b1; i++) @(negedge CLOCK);
    if (DONE !== 1'b1) begin
      n_mismatch++;
      conclude();
    end
  endtask
  // One-cycle load of status word (p=1) or pointer (p=0)
  task automatic ld(input logic p, input logic [15:0] v);
    @(negedge CLOCK);
    PSW_LOAD = p;
    DATA_POINTER_REG_LOAD = !p;
    PSW_DATA = v[7:0];
    DATA_POINTER_REG_DATA = v;
    @(negedge CLOCK);
    PSW_LOAD = 1'b0;
    DATA_POINTER_REG_LOAD = 1'b0;
  endtask
  task automatic set_acc(input logic [7:0] x);
    run(OP_CLR, AM_ACC, 8'h00, 16'h0000);
    run(OP_ADD, AM_IMM, 8'h00, {8'h00, x});
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_arith();
    set_acc(8'h35);
    ld(1'b1, 16'h0080);
    run(OP_ADD_WITH_CARRY, AM_IMM, 8'h00, 16'h0053);
    chk(ACC, 16'h0089);
    ld(1'b1, 16'h0080);
    run(OP_SUBTRACT_WITH_BORROW, AM_IMM, 8'h00, 16'h0010);
    chk(ACC, 16'h0078);
    ld(1'b1, 16'h0000);
    run(OP_ADD, AM_DIRECT, 8'h20, 16'h0000);
    chk(ACC, 16'h0099);
    set_acc(8'hff);
    run(OP_ADD, AM_IMM, 8'h00, 16'h0001);
    chk(PROGRAM_STATUS_WORD & 8'hc4, 16'h00c0);
  endtask
  task automatic t_bank();
    ld(1'b1, 16'h0018);
    set_acc(8'h00);
    run(OP_ADD, AM_INDIRECT, 8'h01, 16'h0000);
    chk(ACC, 16'h001b);
    run(OP_ADD, AM_REG, 8'h05, 16'h0000);
    chk(ACC, 16'h0039);
    ld(1'b1, 16'h0000);
  endtask
  task automatic t_logic();
    set_acc(8'h35);
    run(OP_AND, AM_DIRECT, 8'h52, 16'h0000);
    chk(ACC, 16'h0011);
    run(OP_OR, AM_IMM, 8'h00, 16'h00f0);
    chk(ACC, 16'h00f1);
    run(OP_XOR, AM_INDIRECT, 8'h00, 16'h0000);
    chk(ACC, 16'h00f3);
    run(OP_XOR, AM_IMM, 8'h60, 16'h00ff, 1'b1);
    chk(dmem[8'h60], 16'h009e);
    run(OP_AND, AM_DIRECT, 8'h61, 16'h0000, 1'b1);
    chk(dmem[8'h61], 16'h0062);
    chk(ACC, 16'h00f3);
  endtask
  task automatic t_incdec();
    run(OP_INC, AM_DIRECT, 8'h70, 16'h0000);
    chk(dmem[8'h70], 16'h0072);
    run(OP_DEC, AM_REG, 8'h07, 16'h0000);
    chk(dmem[8'h07], 16'h0007);
    chk(ACC, 16'h00f3);
    run(OP_DEC, AM_ACC, 8'h00, 16'h0000);
    chk(ACC, 16'h00f2);
  endtask
  task automatic t_index();
    ld(1'b0, 16'h12ff);
    run(OP_INC_DP, AM_ACC, 8'h00, 16'h0000);
    chk(DATA_POINTER_REG, 16'h1300);
    set_acc(8'h05);
    run(OP_IDX_RD, AM_DATA_POINTER_REG, 8'h00, 16'h0000);
    chk(ACC, 16'h0016);
    run(OP_IDX_RD, AM_PC, 8'h00, 16'h2010);
    chk(ACC, 16'h0006);
  endtask
  task automatic t_rotate();
    caa_op_t ops [6] = '{OP_RL, OP_RR, OP_RLC, OP_RRC, OP_SWAP, OP_CPL};
    logic [7:0] ex [6] = '{8'h03, 8'h81, 8'h02, 8'h81, 8'h18, 8'he7};
    ld(1'b1, 16'h0000);
    set_acc(8'h81);
    foreach (ops[i]) begin
      run(ops[i], AM_ACC, 8'h00, 16'h0000);
      chk(ACC, {8'h00, ex[i]});
    end
  endtask
  task automatic t_bcd_mul();
    set_acc(8'h38);
    run(OP_ADD, AM_IMM, 8'h00, 16'h0029);
    run(OP_DA, AM_ACC, 8'h00, 16'h0000);
    chk(ACC, 16'h0067);
    ld(1'b1, 16'h0080);
    run(OP_MUL, AM_ACC, 8'h00, 16'h0000);
    chk({B_REG, ACC}, 16'h0000);
    chk(PROGRAM_STATUS_WORD & 8'h80, 16'h0000);
    run(OP_DIV, AM_ACC, 8'h00, 16'h0000);
    chk(PROGRAM_STATUS_WORD & 8'h04, 16'h0004);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Memory fill, reset, then the scenarios
  initial begin
    for (int i = 0; i < 256; i++) dmem[i] = 8'(i + 1);
    repeat (10) @(negedge CLOCK);
    chk({ACC, B_REG}, 16'h0000);
    chk(DATA_POINTER_REG, 16'h0000);
    chk({PROGRAM_STATUS_WORD, 7'h00, BUSY}, 16'h0000);
    RST_N = 1'b1;
    t_arith();
    t_bank();
    t_logic();
    t_incdec();
    t_index();
    t_rotate();
    t_bcd_mul();
    conclude();
  end
endmodule
`default_nettype wire
